// ===== design/eth_led_map.svh
`ifndef ETH_LED_MAP_SVH
`define ETH_LED_MAP_SVH
`define SPEED_10          2'h0
`define SPEED_100         2'h1
`define SPEED_1000        2'h2
`define SPEED_RSVD        2'h3
`define LED_OFF           1'h1
`define LED_ON            1'h0
`define PAIR_UNUSED       2'h0
`define PAIR_TX           2'h1
`define PAIR_RX           2'h2
`define PAIR_BIDIR        2'h3
`define SYNC_DEPTH        3
`endif

// ===== design/eth_led_pkg.sv
package eth_led_pkg;
    typedef logic [1:0] speed_t;
    typedef logic [1:0] pair_role_t;
endpackage : eth_led_pkg

// ===== design/pin_sync.sv
`timescale 1ns/1ns
`include "eth_led_map.svh"
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] next_dout;

    // a change is taken only when the second and third stages agree
    always_comb
    begin
        next_dout = (stage2 == stage3) ? stage3 : dout;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout   <= '0;
        end
        else
        begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout   <= next_dout;
        end
    end
endmodule : pin_sync

// ===== design/ethernet_link_status_indicators.sv
`timescale 1ns/1ns
`include "eth_led_map.svh"
module ethernet_link_status_indicators
    import eth_led_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    input  wire logic                   linkUp,
    input  wire eth_led_pkg::speed_t    linkSpeed,
    input  wire logic                   activity,
    output logic                        eth_activity_led_n,
    output logic                        eth_any_link_led_n,
    output logic                        eth_fast_link_led_n,
    output logic                        eth_gig_link_led_n,
    output eth_led_pkg::pair_role_t     line_pair_0,
    output eth_led_pkg::pair_role_t     line_pair_1,
    output eth_led_pkg::pair_role_t     line_pair_2,
    output eth_led_pkg::pair_role_t     line_pair_3,
    output logic                        speedIs10
);
    import eth_led_pkg::*;

    // filtered copies of the controller inputs
    logic [3:0] syncIn;
    logic       sLink;
    speed_t     sSpeed;
    logic       sAct;
    // next values, registered below
    logic       next_act;
    logic       next_fast;
    logic       next_gig;
    logic       next_any;
    logic       next_s10;
    pair_role_t next_p0;
    pair_role_t next_p1;
    pair_role_t next_p2;
    pair_role_t next_p3;

    // inputs come from the controller's domain, so they are filtered
    // link and speed share one filter, so a half-changed speed code never reaches decode
    // limitation: a traffic burst shorter than two clocks may leave the lamp dark
    pin_sync #(
        .W      (4)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    ({linkUp, linkSpeed, activity}),
        .dout   (syncIn)
    );

    assign sLink  = syncIn[3];
    assign sSpeed = syncIn[2:1];
    assign sAct   = syncIn[0];

    always_comb
    begin
        next_act  = sAct ? `LED_ON : `LED_OFF;
        next_fast = `LED_OFF;
        next_gig  = `LED_OFF;
        next_s10  = 1'h0;
        next_p0   = `PAIR_UNUSED;
        next_p1   = `PAIR_UNUSED;
        next_p2   = `PAIR_UNUSED;
        next_p3   = `PAIR_UNUSED;
        if (sLink)
        begin
            case (sSpeed)
                `SPEED_1000:
                begin
                    next_gig = `LED_ON;
                    next_p0  = `PAIR_BIDIR;
                    next_p1  = `PAIR_BIDIR;
                    next_p2  = `PAIR_BIDIR;
                    next_p3  = `PAIR_BIDIR;
                end
                `SPEED_100:
                begin
                    next_fast = `LED_ON;
                    next_p0   = `PAIR_TX;
                    next_p1   = `PAIR_RX;
                end
                `SPEED_10:
                begin
                    next_s10 = 1'h1;
                    next_p0  = `PAIR_TX;
                    next_p1  = `PAIR_RX;
                end
                // reserved code treated as no usable link
                // a link at an unknown speed cannot light a lamp it cannot name
                default:
                begin
                    next_s10 = 1'h0;
                end
            endcase
        end
        // built from the decoded levels, not from sLink, so the AND holds every cycle
        // any-link is AND of speed levels
        next_any = next_fast & next_gig;
    end

    // lamps and lane roles come straight from flops, so decode hazards never reach the board
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            eth_activity_led_n  <= `LED_OFF;
            eth_any_link_led_n  <= `LED_OFF;
            eth_fast_link_led_n <= `LED_OFF;
            eth_gig_link_led_n  <= `LED_OFF;
            line_pair_0         <= `PAIR_UNUSED;
            line_pair_1         <= `PAIR_UNUSED;
            line_pair_2         <= `PAIR_UNUSED;
            line_pair_3         <= `PAIR_UNUSED;
            speedIs10           <= 1'h0;
        end
        else
        begin
            eth_activity_led_n  <= next_act;
            eth_any_link_led_n  <= next_any;
            eth_fast_link_led_n <= next_fast;
            eth_gig_link_led_n  <= next_gig;
            line_pair_0         <= next_p0;
            line_pair_1         <= next_p1;
            line_pair_2         <= next_p2;
            line_pair_3         <= next_p3;
            speedIs10           <= next_s10;
        end
    end

    // lamp levels against the filtered inputs, one clock later
    AST_ACT: assert property (@(posedge clk) disable iff (!arst_n)
        eth_activity_led_n == !$past(sAct)) else $error("activity led wrong");
    AST_ANY_ON: assert property (@(posedge clk) disable iff (!arst_n)
        $past(sLink) && ($past(sSpeed) == `SPEED_100 || $past(sSpeed) == `SPEED_1000)
        |-> !eth_any_link_led_n) else $error("any link not lit");
    AST_FAST: assert property (@(posedge clk) disable iff (!arst_n)
        !eth_fast_link_led_n == ($past(sLink) && $past(sSpeed) == `SPEED_100))
        else $error("fast led wrong");
    AST_GIG: assert property (@(posedge clk) disable iff (!arst_n)
        !eth_gig_link_led_n == ($past(sLink) && $past(sSpeed) == `SPEED_1000))
        else $error("gig led wrong");

    // relations between the lamps themselves
    AST_TEN: assert property (@(posedge clk) disable iff (!arst_n)
        speedIs10 |-> eth_any_link_led_n && eth_fast_link_led_n && eth_gig_link_led_n)
        else $error("led lit at 10M");
    AST_AND: assert property (@(posedge clk) disable iff (!arst_n)
        eth_any_link_led_n == (eth_fast_link_led_n & eth_gig_link_led_n))
        else $error("any link not AND");
    AST_SPEEDS: assert property (@(posedge clk) disable iff (!arst_n)
        $onehot0({speedIs10, !eth_fast_link_led_n, !eth_gig_link_led_n}))
        else $error("speeds not distinct");

    // lane roles follow the speed of the live link
    AST_PAIRS: assert property (@(posedge clk) disable iff (!arst_n)
        !eth_gig_link_led_n |-> line_pair_2 == `PAIR_BIDIR && line_pair_3 == `PAIR_BIDIR)
        else $error("gig pairs wrong");
    AST_SLOW_PAIRS: assert property (@(posedge clk) disable iff (!arst_n)
        (speedIs10 || !eth_fast_link_led_n) |-> line_pair_0 == `PAIR_TX
        && line_pair_1 == `PAIR_RX && line_pair_2 == `PAIR_UNUSED) else $error("slow pairs");

    // no link means every link lamp dark
    AST_NOLINK: assert property (@(posedge clk) disable iff (!arst_n)
        !$past(sLink) |-> eth_any_link_led_n && eth_fast_link_led_n && eth_gig_link_led_n)
        else $error("led lit without link");

    // exact forms: a lamp stuck lit fails here even where the implications above pass
    AST_ANY_EXACT: assert property (@(posedge clk) disable iff (!arst_n)
        !eth_any_link_led_n == ($past(sLink) && ($past(sSpeed) == `SPEED_100
        || $past(sSpeed) == `SPEED_1000))) else $error("any link level wrong");
    AST_TEN_IN: assert property (@(posedge clk) disable iff (!arst_n)
        $past(sLink) && $past(sSpeed) == `SPEED_10 |-> speedIs10 && eth_any_link_led_n)
        else $error("any link lit at 10M");
    AST_TEN_EXACT: assert property (@(posedge clk) disable iff (!arst_n)
        speedIs10 == ($past(sLink) && $past(sSpeed) == `SPEED_10))
        else $error("10M flag wrong");

    // a reserved speed code shows a dark port rather than a guess at a speed
    AST_RSVD: assert property (@(posedge clk) disable iff (!arst_n)
        $past(sLink) && $past(sSpeed) == `SPEED_RSVD
        |-> eth_any_link_led_n && eth_fast_link_led_n && eth_gig_link_led_n)
        else $error("led lit on reserved speed");
    AST_IDLE_PAIRS: assert property (@(posedge clk) disable iff (!arst_n)
        (!$past(sLink) || $past(sSpeed) == `SPEED_RSVD) |-> !speedIs10
        && line_pair_0 == `PAIR_UNUSED && line_pair_1 == `PAIR_UNUSED
        && line_pair_2 == `PAIR_UNUSED && line_pair_3 == `PAIR_UNUSED)
        else $error("pairs used without link");

    // lane roles: a pair in use must belong to a live link
    AST_GIG_LOW_PAIRS: assert property (@(posedge clk) disable iff (!arst_n)
        !eth_gig_link_led_n |-> line_pair_0 == `PAIR_BIDIR && line_pair_1 == `PAIR_BIDIR)
        else $error("gig low pairs wrong");
    AST_SLOW_TOP_PAIR: assert property (@(posedge clk) disable iff (!arst_n)
        (speedIs10 || !eth_fast_link_led_n) |-> line_pair_3 == `PAIR_UNUSED)
        else $error("slow pair 3 used");
    AST_TX_PAIR_EXACT: assert property (@(posedge clk) disable iff (!arst_n)
        (line_pair_0 == `PAIR_TX) == (speedIs10 || !eth_fast_link_led_n))
        else $error("tx pair role wrong");
    AST_PAIR_ROLES: assert property (@(posedge clk) disable iff (!arst_n)
        line_pair_0 != `PAIR_RX && line_pair_1 != `PAIR_TX)
        else $error("pair roles swapped");
    AST_PAIR_ONLY_LINK: assert property (@(posedge clk) disable iff (!arst_n)
        line_pair_0 != `PAIR_UNUSED |-> !eth_any_link_led_n || speedIs10)
        else $error("pair used without link");
endmodule : ethernet_link_status_indicators

// ===== verif/carrier_leds.sv
`timescale 1ns/1ns
module carrier_leds
(
    input  wire logic       actN,
    input  wire logic       anyN,
    input  wire logic       fastN,
    input  wire logic       gigN,
    output logic      [3:0] lit
);
    // an lamp lights while its line is pulled low
    assign lit = ~{gigN, fastN, anyN, actN};
endmodule : carrier_leds

// ===== verif/test_ethernet_link_status_indicators.sv
`timescale 1ns/1ns
`include "eth_led_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_ethernet_link_status_indicators;
    import eth_led_pkg::*;
    logic       clk, arst_n, linkUp, activity, speedIs10;
    logic       actN, anyN, fastN, gigN;
    speed_t     linkSpeed;
    pair_role_t p0, p1, p2, p3;
    logic [3:0] lit;
    int         errors, checks_done, i;
    int         seed = 32'h2cd61eed;
    ethernet_link_status_indicators DUT (.clk(clk), .arst_n(arst_n), .linkUp(linkUp),
        .linkSpeed(linkSpeed), .activity(activity), .eth_activity_led_n(actN),
        .eth_any_link_led_n(anyN), .eth_fast_link_led_n(fastN), .eth_gig_link_led_n(gigN),
        .line_pair_0(p0), .line_pair_1(p1), .line_pair_2(p2), .line_pair_3(p3),
        .speedIs10(speedIs10));
    carrier_leds board (.actN(actN), .anyN(anyN), .fastN(fastN), .gigN(gigN), .lit(lit));
    function automatic logic [3:0] expLit(logic up, speed_t s, logic act);
        logic fast;
        logic gig;
        fast = up && (s == `SPEED_100);
        gig = up && (s == `SPEED_1000);
        return {gig, fast, fast | gig, act};
    endfunction : expLit
    task automatic finish_test();
        $display("errors %0d checks_done %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task automatic apply(logic up, speed_t s, logic act);
        logic [3:0] e;
        e = expLit(up, s, act);
        @(negedge clk);
        linkUp = up;
        linkSpeed = s;
        activity = act;
        // settles well past the five edge latency
        repeat (8) @(negedge clk);
        `CHK(actN, ~e[0])
        `CHK(anyN, ~e[1])
        `CHK(fastN, ~e[2])
        `CHK(gigN, ~e[3])
        `CHK(lit, e)
        `CHK(speedIs10, up && s == `SPEED_10)
        if (e[3])
            `CHK({p0, p1, p2, p3}, {4{`PAIR_BIDIR}})
        else if (up && s != `SPEED_RSVD)
            `CHK({p0, p1, p2, p3}, {`PAIR_TX, `PAIR_RX, `PAIR_UNUSED, `PAIR_UNUSED})
        else
            `CHK({p0, p1, p2, p3}, {4{`PAIR_UNUSED}})
    endtask : apply
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #100000;
        errors++;
        finish_test();
    end
    initial
    begin
        arst_n = 1'h0;
        linkUp = 1'h0;
        linkSpeed = `SPEED_10;
        activity = 1'h0;
        repeat (8) @(negedge clk);
        `CHK({actN, anyN, fastN, gigN, p0, speedIs10}, 7'h78)
        arst_n = 1'h1;
        for (i = 0; i < 16; i++)
            apply(i[0], speed_t'(i[2:1]), i[3]);
        // exact latency: old level after four edges, new after five
        @(negedge clk);
        linkUp = 1'h1;
        linkSpeed = `SPEED_1000;
        repeat (4) @(posedge clk);
        #1 `CHK(gigN, `LED_OFF)
        @(posedge clk);
        #1 `CHK(gigN, `LED_ON)
        for (i = 0; i < 40; i++)
            apply(1'($random(seed)), speed_t'($random(seed)), 1'($random(seed)));
        // reset in mid-run forces the lamps off at once
        apply(1'h1, `SPEED_100, 1'h1);
        arst_n = 1'h0;
        #1 `CHK({actN, anyN, fastN, gigN, p1, speedIs10}, 7'h78)
        @(negedge clk);
        arst_n = 1'h1;
        apply(1'h1, `SPEED_10, 1'h0);
        apply(1'h1, `SPEED_100, 1'h1);
        finish_test();
    end
endmodule : test_ethernet_link_status_indicators
